// ### include/servo_param_pkg.sv
// Functional notes
// - Responses wait 0-255 half-millisecond steps.
// - Low mask bits choose pin or serial input.
// - High mask bits enable virtual inputs, indexer mode.
// - Virtual inputs carry fixed trigger, select, jog functions.
// - Input status writes affect only masked inputs.
// - Input status bits 0-7 show physical inputs.
// - Newest fault code kept, read-only, zero when empty.
// - Four older fault codes kept in order.
// - Jog writes 0-3000 set jog speed.
// - Jog codes 4998 ccw, 4999 cw, 5000 stop.
// - Jog speed resets to 20 rpm.
// - Jog moves only when enabled without fault.
// - Input function 37 jogs forward, 38 reverse.
// - Five force bits drive outputs active or inactive.
// - Force value changes outputs immediately.
// - Leaving force mode restores normal output functions.
// - Force ignored while servo drive enabled.
// - Output status reports five outputs, read-only.
package servo_param_pkg;

  localparam logic [15:0] RESPONSE_DELAY_ADDR = 16'h0307;
  localparam logic [15:0] INPUT_SOURCE_MASK_ADDR = 16'h0308;
  localparam logic [15:0] FAULT_HISTORY_NEWEST_ADDR = 16'h0400;
  localparam logic [15:0] FAULT_HISTORY_SECOND_ADDR = 16'h0401;
  localparam logic [15:0] FAULT_HISTORY_THIRD_ADDR = 16'h0402;
  localparam logic [15:0] FAULT_HISTORY_FOURTH_ADDR = 16'h0403;
  localparam logic [15:0] FAULT_HISTORY_FIFTH_ADDR = 16'h0404;
  localparam logic [15:0] JOG_COMMAND_ADDR = 16'h0405;
  localparam logic [15:0] OUTPUT_FORCE_ADDR = 16'h0406;
  localparam logic [15:0] INPUT_STATE_ADDR = 16'h0407;
  localparam logic [15:0] SPARE_SLOT_ADDR = 16'h0408;
  localparam logic [15:0] OUTPUT_STATE_ADDR = 16'h0409;

  localparam logic [15:0] RESPONSE_DELAY_RESET = 16'h0000;
  localparam logic [15:0] INPUT_SOURCE_MASK_RESET = 16'h0000;
  localparam logic [15:0] FAULT_HISTORY_RESET = 16'h0000;
  localparam logic [15:0] JOG_SPEED_RESET = 16'h0014;
  localparam logic [4:0] OUTPUT_FORCE_RESET = 5'h00;
  localparam logic [15:0] INPUT_STATE_RESET = 16'h0000;

  localparam logic [15:0] RESPONSE_DELAY_MAX = 16'h00ff;
  localparam logic [15:0] JOG_SPEED_SERIAL_MAX = 16'h0bb8;
  localparam logic [15:0] JOG_CODE_CCW = 16'h1386;
  localparam logic [15:0] JOG_CODE_CW = 16'h1387;
  localparam logic [15:0] JOG_CODE_STOP = 16'h1388;
  localparam logic [15:0] FAULT_CODE_FIRST = 16'h0001;
  localparam logic [15:0] FAULT_CODE_LAST = 16'h0016;
  localparam logic [7:0] DI_FUNC_JOG_FORWARD = 8'h25;
  localparam logic [7:0] DI_FUNC_JOG_REVERSE = 8'h26;

  localparam int NUM_PHYS_INPUTS = 8;
  localparam int NUM_OUTPUTS = 5;
  localparam int FAULT_DEPTH = 5;
  localparam int VIRT_TRIGGER_BIT = 8;
  localparam int VIRT_POS_SELECT0_BIT = 9;
  localparam int VIRT_POS_SELECT2_BIT = 11;
  localparam int VIRT_ALARM_RESET_BIT = 12;
  localparam int VIRT_HOME_START_BIT = 13;
  localparam int VIRT_JOG_FORWARD_BIT = 14;
  localparam int VIRT_JOG_REVERSE_BIT = 15;

  localparam int CLK_FREQ_KHZ = 125000;
  localparam int RESPONSE_STEP_US = 500;
  localparam int RESPONSE_STEP_CYCLES = CLK_FREQ_KHZ * RESPONSE_STEP_US / 1000;

  typedef enum logic [1:0] {
    RESP_IDLE = 2'b00,
    RESP_WAIT = 2'b01,
    RESP_SEND = 2'b11
  } resp_state_type;

  typedef enum logic [1:0] {
    JOG_STOP = 2'b00,
    JOG_CCW = 2'b01,
    JOG_CW = 2'b11
  } jog_state_type;

endpackage

// ### core/servo_io_override_param_bank.sv
`timescale 1ns/1ps
module servo_io_override_param_bank
  import servo_param_pkg::*;
#(
  parameter int STEP_CYCLES = RESPONSE_STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  output logic req_busy_o,
  output logic resp_valid_o,
  output logic [15:0] resp_rdata_o,
  output logic resp_error_o,
  input wire logic [7:0] phys_input_pin_i,
  input wire logic [63:0] phys_input_func_i,
  input wire logic internal_indexer_mode_i,
  input wire logic servo_enabled_i,
  input wire logic fault_active_i,
  input wire logic fault_event_i,
  input wire logic [15:0] fault_code_i,
  input wire logic force_mode_i,
  input wire logic [4:0] normal_output_i,
  output logic [7:0] phys_input_o,
  output logic command_trigger_o,
  output logic [2:0] position_select_o,
  output logic alarm_reset_o,
  output logic home_start_o,
  output logic jog_forward_o,
  output logic jog_reverse_o,
  output logic [15:0] jog_speed_o,
  output logic [4:0] output_drive_o
);

  localparam logic [7:0] STEP_LAST = 8'h00;
  localparam logic [31:0] STEP_CYCLES_LAST = 32'(STEP_CYCLES - 1);

  logic reset_sync_a_q;
  logic reset_sync_b_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reset_sync_a_q <= 1'b0;
      reset_sync_b_q <= 1'b0;
    end else begin
      reset_sync_a_q <= 1'b1;
      reset_sync_b_q <= reset_sync_a_q;
    end
  end

  assign rst_n = reset_sync_b_q;

  logic [15:0] response_delay_q;
  logic [15:0] input_source_mask_q;
  logic [15:0] input_state_q;
  logic [4:0] output_force_q;
  logic [15:0] jog_speed_q;
  jog_state_type jog_state_q;
  logic [15:0] fault_hist_q [FAULT_DEPTH];
  resp_state_type resp_state_q;
  logic [7:0] steps_left_q;
  logic [31:0] tick_count_q;
  logic [15:0] rdata_q;
  logic error_q;
  logic resp_valid_q;
  logic busy_q;

  logic [7:0] phys_eff_q;
  logic [7:0] virt_eff_q;
  logic jog_forward_q;
  logic jog_reverse_q;
  logic [4:0] output_drive_q;

  // Request acceptance and register decode.
  wire take = req_valid_i && (resp_state_q == RESP_IDLE);
  wire wr = take && req_write_i;
  wire hit_delay = (req_addr_i == RESPONSE_DELAY_ADDR);
  wire hit_mask = (req_addr_i == INPUT_SOURCE_MASK_ADDR);
  wire hit_f0 = (req_addr_i == FAULT_HISTORY_NEWEST_ADDR);
  wire hit_f1 = (req_addr_i == FAULT_HISTORY_SECOND_ADDR);
  wire hit_f2 = (req_addr_i == FAULT_HISTORY_THIRD_ADDR);
  wire hit_f3 = (req_addr_i == FAULT_HISTORY_FOURTH_ADDR);
  wire hit_f4 = (req_addr_i == FAULT_HISTORY_FIFTH_ADDR);
  wire hit_fault = hit_f0 | hit_f1 | hit_f2 | hit_f3 | hit_f4;
  wire hit_jog = (req_addr_i == JOG_COMMAND_ADDR);
  wire hit_force = (req_addr_i == OUTPUT_FORCE_ADDR);
  wire hit_in = (req_addr_i == INPUT_STATE_ADDR);
  wire hit_spare = (req_addr_i == SPARE_SLOT_ADDR);
  wire hit_out = (req_addr_i == OUTPUT_STATE_ADDR);
  wire hit_any = hit_delay | hit_mask | hit_fault | hit_jog | hit_force | hit_in | hit_spare | hit_out;

  wire delay_ok = (req_wdata_i <= RESPONSE_DELAY_MAX);
  wire force_ok = (req_wdata_i[15:NUM_OUTPUTS] == '0);
  wire jog_is_speed = (req_wdata_i <= JOG_SPEED_SERIAL_MAX);
  wire jog_is_ccw = (req_wdata_i == JOG_CODE_CCW);
  wire jog_is_cw = (req_wdata_i == JOG_CODE_CW);
  wire jog_is_stop = (req_wdata_i == JOG_CODE_STOP);
  wire jog_ok = jog_is_speed | jog_is_ccw | jog_is_cw | jog_is_stop;

  // Writes to read-only words, out-of-range values and unmapped words are refused.
  wire bad_write = !hit_any || hit_fault || hit_out || (hit_delay && !delay_ok)
                   || (hit_force && !force_ok) || (hit_jog && !jog_ok);
  wire req_error = req_write_i ? bad_write : !hit_any;

  wire wr_ok = wr && !bad_write;

  // Effective input levels and the view read back from the input status word.
  wire [7:0] mask_lo = input_source_mask_q[7:0];
  wire [7:0] mask_hi = input_source_mask_q[15:8];
  wire [7:0] phys_eff = (phys_input_pin_i & ~mask_lo) | (input_state_q[7:0] & mask_lo);
  wire [7:0] virt_eff = internal_indexer_mode_i ? (input_state_q[15:8] & mask_hi) : 8'h00;
  wire [15:0] input_view = {virt_eff, phys_eff};

  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_delay) begin
      rd_mux = response_delay_q;
    end else if (hit_mask) begin
      rd_mux = input_source_mask_q;
    end else if (hit_f0) begin
      rd_mux = fault_hist_q[0];
    end else if (hit_f1) begin
      rd_mux = fault_hist_q[1];
    end else if (hit_f2) begin
      rd_mux = fault_hist_q[2];
    end else if (hit_f3) begin
      rd_mux = fault_hist_q[3];
    end else if (hit_f4) begin
      rd_mux = fault_hist_q[4];
    end else if (hit_jog) begin
      rd_mux = jog_speed_q;
    end else if (hit_force) begin
      rd_mux = {11'h000, output_force_q};
    end else if (hit_in) begin
      rd_mux = input_view;
    end else if (hit_out) begin
      rd_mux = {11'h000, output_drive_q};
    end
  end

  // Response pacing: each step is a half-millisecond count of clock cycles.
  wire step_tick = (tick_count_q == STEP_CYCLES_LAST);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      resp_state_q <= RESP_IDLE;
      steps_left_q <= 8'h00;
      tick_count_q <= 32'h0000_0000;
      rdata_q <= 16'h0000;
      error_q <= 1'b0;
      resp_valid_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      resp_valid_q <= 1'b0;
      case (resp_state_q)
        RESP_IDLE: begin
          tick_count_q <= 32'h0000_0000;
          if (take) begin
            busy_q <= 1'b1;
            rdata_q <= req_write_i ? 16'h0000 : rd_mux;
            error_q <= req_error;
            steps_left_q <= response_delay_q[7:0];
            resp_state_q <= (response_delay_q[7:0] == STEP_LAST) ? RESP_SEND : RESP_WAIT;
          end
        end
        RESP_WAIT: begin
          if (step_tick) begin
            tick_count_q <= 32'h0000_0000;
            steps_left_q <= steps_left_q - 8'h01;
            if (steps_left_q == 8'h01) begin
              resp_state_q <= RESP_SEND;
            end
          end else begin
            tick_count_q <= tick_count_q + 32'h0000_0001;
          end
        end
        RESP_SEND: begin
          resp_valid_q <= 1'b1;
          busy_q <= 1'b0;
          resp_state_q <= RESP_IDLE;
        end
        default: begin
          busy_q <= 1'b0;
          resp_state_q <= RESP_IDLE;
        end
      endcase
    end
  end

  // Software-written configuration words.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      response_delay_q <= RESPONSE_DELAY_RESET;
      input_source_mask_q <= INPUT_SOURCE_MASK_RESET;
      output_force_q <= OUTPUT_FORCE_RESET;
    end else if (wr_ok) begin
      if (hit_delay) begin
        response_delay_q <= req_wdata_i;
      end
      if (hit_mask) begin
        input_source_mask_q <= req_wdata_i;
      end
      if (hit_force) begin
        output_force_q <= req_wdata_i[NUM_OUTPUTS-1:0];
      end
    end
  end

  // Only bits handed to serial control take the written value.
  wire [15:0] in_write_mask = (wr_ok && hit_in) ? input_source_mask_q : 16'h0000;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      input_state_q <= INPUT_STATE_RESET;
    end else begin
      input_state_q <= (input_state_q & ~in_write_mask) | (req_wdata_i & in_write_mask);
    end
  end

  // Serial jog: a speed value is stored, a code steers the jog state.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      jog_speed_q <= JOG_SPEED_RESET;
      jog_state_q <= JOG_STOP;
    end else if (wr_ok && hit_jog) begin
      if (jog_is_speed) begin
        jog_speed_q <= req_wdata_i;
      end else if (jog_is_ccw) begin
        jog_state_q <= JOG_CCW;
      end else if (jog_is_cw) begin
        jog_state_q <= JOG_CW;
      end else begin
        jog_state_q <= JOG_STOP;
      end
    end
  end

  // Fault history shifts one place older on each accepted fault code.
  wire fault_in_range = (fault_code_i >= FAULT_CODE_FIRST) && (fault_code_i <= FAULT_CODE_LAST);
  wire fault_push = fault_event_i && fault_in_range;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < FAULT_DEPTH; i++) begin
        fault_hist_q[i] <= FAULT_HISTORY_RESET;
      end
    end else if (fault_push) begin
      fault_hist_q[0] <= fault_code_i;
      for (int i = 1; i < FAULT_DEPTH; i++) begin
        fault_hist_q[i] <= fault_hist_q[i-1];
      end
    end
  end

  // Physical inputs assigned to the jog functions.
  logic [7:0] di_jog_fwd;
  logic [7:0] di_jog_rev;
  genvar g;
  generate
    for (g = 0; g < NUM_PHYS_INPUTS; g++) begin : g_di_func
      assign di_jog_fwd[g] = phys_eff[g] && (phys_input_func_i[g*8 +: 8] == DI_FUNC_JOG_FORWARD);
      assign di_jog_rev[g] = phys_eff[g] && (phys_input_func_i[g*8 +: 8] == DI_FUNC_JOG_REVERSE);
    end
  endgenerate

  wire jog_allowed = servo_enabled_i && !fault_active_i;
  wire fwd_req = (|di_jog_fwd) || virt_eff[VIRT_JOG_FORWARD_BIT-8] || (jog_state_q == JOG_CW);
  wire rev_req = (|di_jog_rev) || virt_eff[VIRT_JOG_REVERSE_BIT-8] || (jog_state_q == JOG_CCW);
  // Opposing requests cancel so the motor never sees both directions at once.
  wire jog_fwd_d = jog_allowed && fwd_req && !rev_req;
  wire jog_rev_d = jog_allowed && rev_req && !fwd_req;

  // Forcing holds only while the force mode is entered and the drive is disabled.
  wire force_on = force_mode_i && !servo_enabled_i;
  wire [4:0] output_d = force_on ? output_force_q : normal_output_i;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phys_eff_q <= 8'h00;
      virt_eff_q <= 8'h00;
      jog_forward_q <= 1'b0;
      jog_reverse_q <= 1'b0;
      output_drive_q <= 5'h00;
    end else begin
      phys_eff_q <= phys_eff;
      virt_eff_q <= virt_eff;
      jog_forward_q <= jog_fwd_d;
      jog_reverse_q <= jog_rev_d;
      output_drive_q <= output_d;
    end
  end

  assign req_busy_o = busy_q;
  assign resp_valid_o = resp_valid_q;
  assign resp_rdata_o = rdata_q;
  assign resp_error_o = error_q;
  assign phys_input_o = phys_eff_q;
  assign command_trigger_o = virt_eff_q[VIRT_TRIGGER_BIT-8];
  assign position_select_o = virt_eff_q[VIRT_POS_SELECT2_BIT-8:VIRT_POS_SELECT0_BIT-8];
  assign alarm_reset_o = virt_eff_q[VIRT_ALARM_RESET_BIT-8];
  assign home_start_o = virt_eff_q[VIRT_HOME_START_BIT-8];
  assign jog_forward_o = jog_forward_q;
  assign jog_reverse_o = jog_reverse_q;
  assign jog_speed_o = jog_speed_q;
  assign output_drive_o = output_drive_q;

endmodule

// ### bench/bank_checker_sva.sv
`timescale 1ns/1ps
module bank_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_busy_o,
  input wire logic resp_valid_o,
  input wire logic [15:0] resp_rdata_o,
  input wire logic [7:0] phys_input_pin_i,
  input wire logic servo_enabled_i,
  input wire logic fault_active_i,
  input wire logic force_mode_i,
  input wire logic [4:0] normal_output_i,
  input wire logic [7:0] phys_input_o,
  input wire logic jog_forward_o,
  input wire logic jog_reverse_o,
  input wire logic [15:0] jog_speed_o,
  input wire logic [4:0] output_drive_o
);
  // The design's own reset lags the pin by two flops, so checking starts one edge after that.
  logic [2:0] live_q;
  wire take = req_valid_i && !req_busy_o;
  wire wtake = take && req_write_i;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      live_q <= 3'h0;
    end else begin
      live_q <= {live_q[1:0], 1'b1};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!live_q[2]);
  a_take_sets_busy: assert property (take |=> req_busy_o) else $error("busy not raised after take");
  a_resp_ends_busy: assert property (resp_valid_o |-> !req_busy_o && $past(req_busy_o))
    else $error("busy wrong at answer");
  a_resp_one_cycle: assert property (resp_valid_o |=> !resp_valid_o) else $error("answer longer than a cycle");
  a_rdata_from_take: assert property ($changed(resp_rdata_o) |-> $past(take)) else $error("read data moved alone");
  a_speed_by_write: assert property ($changed(jog_speed_o) |-> $past(wtake)) else $error("jog speed moved alone");
  a_jog_not_both: assert property (!(jog_forward_o && jog_reverse_o)) else $error("jog both ways");
  a_jog_needs_enable: assert property ((jog_forward_o || jog_reverse_o) |->
    $past(servo_enabled_i && !fault_active_i)) else $error("jog without enable");
  a_force_ignored: assert property ((!force_mode_i || servo_enabled_i) |=>
    output_drive_o == $past(normal_output_i)) else $error("outputs not normal");
  a_input_has_cause: assert property ($changed(phys_input_o) |->
    ($past(phys_input_pin_i, 1) != $past(phys_input_pin_i, 2)) || $past(wtake) || $past(wtake, 2))
    else $error("input moved alone");
endmodule
bind servo_io_override_param_bank bank_checker u_bank_checker (.clk_i, .reset_n_i, .req_valid_i, .req_write_i,
  .req_busy_o, .resp_valid_o, .resp_rdata_o, .phys_input_pin_i, .servo_enabled_i, .fault_active_i, .force_mode_i,
  .normal_output_i, .phys_input_o, .jog_forward_o, .jog_reverse_o, .jog_speed_o, .output_drive_o);

// ### bench/master_model.sv
`timescale 1ns/1ps
module master_model (
  input wire logic clk_i,
  input wire logic req_busy_i,
  input wire logic resp_valid_i,
  input wire logic [15:0] resp_rdata_i,
  input wire logic resp_error_i,
  output logic req_valid_o,
  output logic req_write_o,
  output logic [15:0] req_addr_o,
  output logic [15:0] req_wdata_o
);
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_addr_o = 16'h0000;
    req_wdata_o = 16'h0000;
  end
  // The flash-write limit lives outside this bank, so no access to it is issued here.
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] rd, output logic err, output int cyc);
    int n;
    n = 0;
    rd = 16'h0000;
    err = 1'b0;
    cyc = -1;
    @(negedge clk_i);
    req_valid_o = 1'b1;
    req_write_o = wr;
    req_addr_o = a;
    req_wdata_o = d;
    while (req_busy_i !== 1'b0 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    if (n < 2000) begin
      @(negedge clk_i);
      // Released lines show the inverse so a stale value can never pass for a request.
      req_valid_o = 1'b0;
      req_write_o = ~wr;
      req_addr_o = ~a;
      req_wdata_o = ~d;
      n = 1;
      while (resp_valid_i !== 1'b1 && n < 2000) begin
        @(negedge clk_i);
        n++;
      end
      if (n < 2000) begin
        rd = resp_rdata_i;
        err = resp_error_i;
        cyc = n;
      end
    end
  endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
  import servo_param_pkg::*;
  localparam int STEP = 4;
  logic clk_i = 1'b0, reset_n_i = 1'b0;
  logic req_valid_i, req_write_i, req_busy_o, resp_valid_o, resp_error_o, internal_indexer_mode_i = 1'b0;
  logic servo_enabled_i = 1'b0, fault_active_i = 1'b0, fault_event_i = 1'b0, force_mode_i = 1'b0;
  logic command_trigger_o, alarm_reset_o, home_start_o, jog_forward_o, jog_reverse_o, er;
  logic [15:0] req_addr_i, req_wdata_i, resp_rdata_o, jog_speed_o, rd, fault_code_i = 16'h0000;
  logic [7:0] phys_input_pin_i = 8'h00, phys_input_o;
  logic [63:0] phys_input_func_i = 64'h0;
  logic [4:0] normal_output_i = 5'h0a, output_drive_o;
  logic [2:0] position_select_o;
  int fails = 0, comparisons = 0, cyc;
  int dl[3] = '{0, 3, 255};
  logic [15:0] fc[7] = '{16'h0001, 16'h0002, 16'h0003, 16'h0017, 16'h0004, 16'h0005, 16'h0016};
  logic [15:0] fe[5] = '{16'h0016, 16'h0005, 16'h0004, 16'h0003, 16'h0002};
  servo_io_override_param_bank #(.STEP_CYCLES(STEP)) u_servo_io_override_param_bank (.clk_i, .reset_n_i,
    .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i, .req_busy_o, .resp_valid_o, .resp_rdata_o, .resp_error_o,
    .phys_input_pin_i, .phys_input_func_i, .internal_indexer_mode_i, .servo_enabled_i, .fault_active_i,
    .fault_event_i, .fault_code_i, .force_mode_i, .normal_output_i, .phys_input_o, .command_trigger_o,
    .position_select_o, .alarm_reset_o, .home_start_o, .jog_forward_o, .jog_reverse_o, .jog_speed_o, .output_drive_o);
  master_model u_master_model (.clk_i, .req_busy_i(req_busy_o), .resp_valid_i(resp_valid_o),
    .resp_rdata_i(resp_rdata_o), .resp_error_i(resp_error_o), .req_valid_o(req_valid_i), .req_write_o(req_write_i),
    .req_addr_o(req_addr_i), .req_wdata_o(req_wdata_i));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic e);
    u_master_model.access(wr, a, d, rd, er, cyc);
    if (cyc < 0) begin
      fails++;
      results();
    end else check(16'(er), 16'(e));
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000, 1'b0);
    check(rd, exp);
  endtask
  task automatic settle;
    repeat (2) @(negedge clk_i);
  endtask
  initial begin
    repeat (16) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rdchk(RESPONSE_DELAY_ADDR, 16'h0000);
    rdchk(INPUT_SOURCE_MASK_ADDR, 16'h0000);
    for (int i = 0; i < 5; i++) rdchk(FAULT_HISTORY_NEWEST_ADDR + 16'(i), 16'h0000);
    rdchk(JOG_COMMAND_ADDR, 16'h0014);
    rdchk(OUTPUT_FORCE_ADDR, 16'h0000);
    rdchk(SPARE_SLOT_ADDR, 16'h0000);
    rdchk(OUTPUT_STATE_ADDR, 16'h000a);
    acc(1'b0, 16'h0500, 16'h0000, 1'b1);
    acc(1'b1, FAULT_HISTORY_NEWEST_ADDR, 16'h0001, 1'b1);
    acc(1'b1, OUTPUT_STATE_ADDR, 16'h0001, 1'b1);
    foreach (dl[i]) begin
      acc(1'b1, RESPONSE_DELAY_ADDR, 16'(dl[i]), 1'b0);
      rdchk(RESPONSE_DELAY_ADDR, 16'(dl[i]));
      check(16'(cyc), 16'(dl[i] * STEP + 2));
    end
    acc(1'b1, RESPONSE_DELAY_ADDR, 16'h0100, 1'b1);
    acc(1'b1, RESPONSE_DELAY_ADDR, 16'h0000, 1'b0);
    phys_input_pin_i = 8'ha5;
    acc(1'b1, INPUT_SOURCE_MASK_ADDR, 16'hfff0, 1'b0);
    acc(1'b1, INPUT_STATE_ADDR, 16'h1f33, 1'b0);
    check(16'(phys_input_o), 16'h0035);
    rdchk(INPUT_STATE_ADDR, 16'h0035);
    check(16'({home_start_o, alarm_reset_o, position_select_o, command_trigger_o}), 16'h0000);
    internal_indexer_mode_i = 1'b1;
    acc(1'b1, INPUT_STATE_ADDR, 16'h1f33, 1'b0);
    check(16'({home_start_o, alarm_reset_o, position_select_o, command_trigger_o}), 16'h001f);
    acc(1'b1, INPUT_SOURCE_MASK_ADDR, 16'h10f0, 1'b0);
    acc(1'b1, INPUT_STATE_ADDR, 16'hff00, 1'b0);
    check(16'({home_start_o, alarm_reset_o, position_select_o, command_trigger_o}), 16'h0010);
    phys_input_pin_i = 8'h5a;
    settle();
    check(16'(phys_input_o), 16'h000a);
    acc(1'b1, INPUT_SOURCE_MASK_ADDR, 16'h0000, 1'b0);
    internal_indexer_mode_i = 1'b0;
    foreach (fc[i]) begin
      @(negedge clk_i);
      fault_code_i = fc[i];
      fault_event_i = 1'b1;
      @(negedge clk_i);
      fault_event_i = 1'b0;
    end
    foreach (fe[i]) rdchk(FAULT_HISTORY_NEWEST_ADDR + 16'(i), fe[i]);
    acc(1'b1, JOG_COMMAND_ADDR, 16'd3000, 1'b0);
    acc(1'b1, JOG_COMMAND_ADDR, 16'd3001, 1'b1);
    check(jog_speed_o, 16'h0bb8);
    acc(1'b1, JOG_COMMAND_ADDR, JOG_CODE_CW, 1'b0);
    check(16'({jog_forward_o, jog_reverse_o}), 16'h0000);
    servo_enabled_i = 1'b1;
    settle();
    check(16'({jog_forward_o, jog_reverse_o}), 16'h0002);
    fault_active_i = 1'b1;
    settle();
    check(16'({jog_forward_o, jog_reverse_o}), 16'h0000);
    fault_active_i = 1'b0;
    acc(1'b1, JOG_COMMAND_ADDR, JOG_CODE_CCW, 1'b0);
    check(16'({jog_forward_o, jog_reverse_o}), 16'h0001);
    acc(1'b1, JOG_COMMAND_ADDR, JOG_CODE_STOP, 1'b0);
    check(16'({jog_forward_o, jog_reverse_o}), 16'h0000);
    phys_input_pin_i = 8'h01;
    for (int i = 0; i < 2; i++) begin
      phys_input_func_i = {56'h0, DI_FUNC_JOG_FORWARD + 8'(i)};
      settle();
      check(16'({jog_forward_o, jog_reverse_o}), 16'(2'b10 >> i));
    end
    phys_input_func_i = 64'h0;
    internal_indexer_mode_i = 1'b1;
    acc(1'b1, INPUT_SOURCE_MASK_ADDR, 16'hc000, 1'b0);
    acc(1'b1, INPUT_STATE_ADDR, 16'h4000, 1'b0);
    check(16'({jog_forward_o, jog_reverse_o}), 16'h0002);
    servo_enabled_i = 1'b0;
    force_mode_i = 1'b1;
    acc(1'b1, OUTPUT_FORCE_ADDR, 16'h0015, 1'b0);
    check(16'(output_drive_o), 16'h0015);
    rdchk(OUTPUT_STATE_ADDR, 16'h0015);
    acc(1'b1, OUTPUT_FORCE_ADDR, 16'h0020, 1'b1);
    servo_enabled_i = 1'b1;
    settle();
    check(16'(output_drive_o), 16'h000a);
    servo_enabled_i = 1'b0;
    settle();
    check(16'(output_drive_o), 16'h0015);
    force_mode_i = 1'b0;
    settle();
    check(16'(output_drive_o), 16'h000a);
    results();
  end
endmodule
